// >>> design/rcrb_pkg.sv
// Package for the radio configuration register bank.
// Holds register indices, field positions, reset values, timing constants and the configuration type.
// Assumes a 40 MHz register clock and a 32-bit Avalon-MM register bus.
`default_nettype none

package rcrb_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_CCA_THRESHOLD = 10'h03F;
  localparam logic [9:0] IDX_RF_CHANNEL    = 10'h200;
  localparam logic [9:0] IDX_VCO_OPTIMISE  = 10'h201;
  localparam logic [9:0] IDX_SYNTH_CTRL    = 10'h202;
  localparam logic [9:0] IDX_TX_POWER      = 10'h203;
  localparam logic [9:0] IDX_BATTERY_THR   = 10'h205;
  localparam logic [9:0] IDX_FILTER_CTRL   = 10'h206;
  localparam logic [9:0] IDX_RX_STATUS     = 10'h030;
  localparam logic [9:0] IDX_EVENT_STATUS  = 10'h031;

  // Field positions inside the 8-bit registers.
  localparam int CHANNEL_LSB      = 4;
  localparam int RF_OPT_LSB       = 0;
  localparam int SYNTH_EN_BIT     = 7;
  localparam int TX_COARSE_LSB    = 6;
  localparam int TX_FINE_LSB      = 3;
  localparam int BATT_THR_LSB     = 4;
  localparam int TX_FILTER_BIT    = 7;
  localparam int FAST_WAKE_BIT    = 4;
  localparam int BATT_EN_BIT      = 3;
  localparam int BATT_LOW_BIT     = 5;
  localparam int RX_REFUSED_BIT   = 0;
  localparam int TX_REFUSED_BIT   = 1;

  // Values after reset.
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  // Channel code 0 is 2405 MHz, each step adds 5 MHz.
  localparam logic [11:0] BASE_FREQ_MHZ = 12'h965;
  localparam logic [11:0] FREQ_STEP_MHZ = 12'h005;

  // Attenuation in tenths of a dB: coarse step of 10 dB, fine table by code.
  localparam logic [8:0] COARSE_STEP_TENTHS = 9'h064;
  localparam logic [7:0][8:0] FINE_TENTHS = {9'h03F, 9'h031, 9'h025, 9'h01C,
                                             9'h013, 9'h00C, 9'h005, 9'h000};

  // Battery threshold codes 0111 to 1110 in millivolts, indexed by code minus 7.
  localparam logic [3:0] BATT_CODE_MIN = 4'h7;
  localparam logic [3:0] BATT_CODE_MAX = 4'hE;
  localparam logic [7:0][11:0] BATT_MV = {12'hDAC, 12'hCE4, 12'hC80, 12'hC1C,
                                          12'hAF0, 12'hA8C, 12'hA28, 12'h9C4};

  // Wake time from sleep; the count lasts the limit plus one cycle, which equals the stated bound.
  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned WAKE_FAST_NS      = 1000000;
  localparam int unsigned WAKE_SLOW_NS      = 3000000;
  localparam int unsigned WAKE_FAST_CYCLES  = WAKE_FAST_NS / CLK_PERIOD_NS - 1;
  localparam int unsigned WAKE_SLOW_CYCLES  = WAKE_SLOW_NS / CLK_PERIOD_NS - 1;
  localparam int          WAKE_CNT_W        = 17;

  // Configuration that the radio logic consumes.
  typedef struct packed {
    logic [7:0] cca_threshold;
    logic [3:0] channel;
    logic [3:0] rf_optimise_field;
    logic [7:0] vco_optimise_field;
    logic       synth_enable;
    logic [1:0] tx_power_coarse;
    logic [2:0] tx_power_fine;
    logic [3:0] battery_threshold;
    logic       tx_filter_control;
    logic       fast_clock_wake;
    logic       battery_monitor_enable;
  } rcrb_cfg_s;

  localparam rcrb_cfg_s CFG_RESET = '0;

endpackage : rcrb_pkg

`default_nettype wire

// >>> design/rcrb_battery_monitor.sv
// Battery low-voltage monitor of the radio configuration register bank.
// Assumes the supply measurement in millivolts comes from logic on ref_clk.
`default_nettype none

module rcrb_battery_monitor
  import rcrb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic [3:0]  threshold,
  input  wire logic [11:0] supply_mv,
  output var  logic        low_flag,
  output var  logic        threshold_valid
);

  // Only codes 0111 to 1110 name a voltage; the rest never raise the flag.
  logic        code_ok;
  logic [2:0]  table_idx;
  logic [11:0] limit_mv;
  logic        next_low;

  assign code_ok   = (threshold >= BATT_CODE_MIN) && (threshold <= BATT_CODE_MAX);
  assign table_idx = 3'(threshold - BATT_CODE_MIN);
  assign limit_mv  = BATT_MV[table_idx];
  assign next_low  = enable && code_ok && (supply_mv < limit_mv);

  // The flag is dropped on the next clock edge after the monitor is disabled.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_flag        <= 1'b0;
      threshold_valid <= 1'b0;
    end else begin
      low_flag        <= next_low;
      threshold_valid <= code_ok;
    end
  end

endmodule // rcrb_battery_monitor

`default_nettype wire

// >>> design/rcrb_register_bank.sv
// Configuration register bank of a 2.4 GHz radio transceiver, reached over Avalon-MM.
// Assumes radio-side inputs (signal strength, requests, supply level) come from ref_clk logic.
//
// Behaviour
// - An 8-bit energy threshold is held and the channel is reported busy when energy exceeds it.
// - The threshold is compared on the same 8-bit scale as the signal strength measurement.
// - The channel number comes from bits 7-4 of the first RF control register, 2405 MHz + 5 MHz per code.
// - The synthesizer is enabled by bit 7 of its control register and disabled after reset.
// - Reception and transmission only start while the synthesizer enable bit is set.
// - Coarse transmit attenuation from bits 7-6 gives 0, -10, -20 or -30 dB.
// - Fine transmit attenuation from bits 5-3 follows its table and adds to the coarse step.
// - The battery threshold code in bits 7-4 maps to a voltage, codes outside 0111 to 1110 being undefined.
// - The battery monitor runs only while bit 3 of the sixth RF control register is set.
// - The battery low result shows in bit 5 of the receive status register.
// - The 20 MHz clock wakes in under 1 ms when bit 4 is set and in under 3 ms when clear; the logic takes exactly 1 ms and 3 ms.
//
// The Avalon-MM register port was chosen for this implementation.
`default_nettype none

module rcrb_register_bank
  import rcrb_pkg::*;
#(
  parameter int unsigned WAKE_FAST_LIMIT = WAKE_FAST_CYCLES,
  parameter int unsigned WAKE_SLOW_LIMIT = WAKE_SLOW_CYCLES
)(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Avalon-MM slave.
  input  wire logic [11:0]         avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output var  logic [31:0]         avs_readdata,
  output var  logic                avs_waitrequest,
  // Radio side.
  input  wire logic [7:0]          rssi_level,
  input  wire logic                rx_request,
  input  wire logic                tx_request,
  input  wire logic                wake_request,
  input  wire logic [11:0]         supply_mv,
  output var  rcrb_pkg::rcrb_cfg_s cfg,
  output var  logic                channel_busy,
  output var  logic [11:0]         channel_freq_mhz,
  output var  logic [8:0]          tx_atten_tenths,
  output var  logic                rx_start,
  output var  logic                tx_start,
  output var  logic                clock_ready,
  output var  logic                battery_low_flag,
  output var  logic                battery_threshold_valid
);

  // Bus decode. Registers are eight bits wide and live in byte lane 0.
  logic [9:0] reg_index;
  logic       request;
  logic       accept;
  logic       write_hit;
  logic [7:0] wdata;

  // Word addressing: the two low address bits pick a byte lane and take no part in decode.
  assign reg_index = avs_address[11:2];
  // The master never raises read and write together, so either one means a request.
  assign request   = avs_read || avs_write;
  // The access completes on the edge where waitrequest is seen low.
  assign accept    = request && !avs_waitrequest;
  // A write without byte lane 0 is dropped, since every field lives in that lane.
  assign write_hit = accept && avs_write && avs_byteenable[0];
  assign wdata     = avs_writedata[7:0];

  // One select per mapped index; at most one of them is high for any address.
  logic sel_cca;
  logic sel_rf;
  logic sel_vco;
  logic sel_syn;
  logic sel_pwr;
  logic sel_bat;
  logic sel_flt;
  logic sel_rxs;
  logic sel_evt;

  assign sel_cca = (reg_index == IDX_CCA_THRESHOLD);
  assign sel_rf  = (reg_index == IDX_RF_CHANNEL);
  assign sel_vco = (reg_index == IDX_VCO_OPTIMISE);
  assign sel_syn = (reg_index == IDX_SYNTH_CTRL);
  assign sel_pwr = (reg_index == IDX_TX_POWER);
  assign sel_bat = (reg_index == IDX_BATTERY_THR);
  assign sel_flt = (reg_index == IDX_FILTER_CTRL);
  assign sel_rxs = (reg_index == IDX_RX_STATUS);
  assign sel_evt = (reg_index == IDX_EVENT_STATUS);

  // Event flags for requests turned away because the synthesizer was off.
  // Software reads them from the event status register and clears them there.
  logic rx_refused;
  logic tx_refused;

  // Read views. Reserved bits are not stored, so they read as zero whatever was written.
  logic [7:0] rd_cca;
  logic [7:0] rd_rf;
  logic [7:0] rd_syn;
  logic [7:0] rd_pwr;
  logic [7:0] rd_bat;
  logic [7:0] rd_flt;
  logic [7:0] rd_rxs;
  logic [7:0] rd_evt;
  logic [7:0] rd_byte;

  // Each view packs the stored fields back into their bit positions.
  assign rd_cca = cfg.cca_threshold;
  assign rd_rf  = {cfg.channel, cfg.rf_optimise_field};
  assign rd_syn = {cfg.synth_enable, 7'h00};
  assign rd_pwr = {cfg.tx_power_coarse, cfg.tx_power_fine, 3'h0};
  assign rd_bat = {cfg.battery_threshold, 4'h0};
  assign rd_flt = {cfg.tx_filter_control, 2'h0, cfg.fast_clock_wake,
                   cfg.battery_monitor_enable, 3'h0};
  // The receive status register carries only the battery low result; other bits read zero.
  assign rd_rxs = 8'(battery_low_flag) << BATT_LOW_BIT;
  assign rd_evt = (8'(rx_refused) << RX_REFUSED_BIT) | (8'(tx_refused) << TX_REFUSED_BIT);

  // Unmapped indices read as zero and ignore writes.
  // A priority chain is used; with one-hot selects its order does not matter.
  assign rd_byte = sel_cca ? rd_cca :
                   sel_rf  ? rd_rf  :
                   sel_vco ? cfg.vco_optimise_field :
                   sel_syn ? rd_syn :
                   sel_pwr ? rd_pwr :
                   sel_bat ? rd_bat :
                   sel_flt ? rd_flt :
                   sel_rxs ? rd_rxs :
                   sel_evt ? rd_evt : REG_RESET;

  // One wait cycle per access: waitrequest drops for one cycle, then rises again,
  // so a master that holds its request never sees two completions in a row.
  logic        next_waitrequest;
  logic [31:0] next_readdata;

  // Read data is zero outside the answer cycle, so a late sample shows up as a wrong value.
  assign next_waitrequest = !(request && avs_waitrequest);
  assign next_readdata    = (request && avs_waitrequest && avs_read) ?
                            {24'h000000, rd_byte} : READ_ZERO;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= READ_ZERO;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
    end
  end

  // Configuration fields. Only implemented bits are stored; reserved bits are dropped.
  rcrb_cfg_s next_cfg;

  always_comb begin
    // Start from the held value so fields that are not written keep their contents.
    next_cfg = cfg;
    // Each register has its own select, so at most one branch below applies per access.
    if (write_hit && sel_cca) begin
      next_cfg.cca_threshold = wdata;
    end
    if (write_hit && sel_rf) begin
      next_cfg.channel           = wdata[CHANNEL_LSB +: 4];
      next_cfg.rf_optimise_field = wdata[RF_OPT_LSB +: 4];
    end
    if (write_hit && sel_vco) begin
      next_cfg.vco_optimise_field = wdata;
    end
    if (write_hit && sel_syn) begin
      next_cfg.synth_enable = wdata[SYNTH_EN_BIT];
    end
    if (write_hit && sel_pwr) begin
      next_cfg.tx_power_coarse = wdata[TX_COARSE_LSB +: 2];
      next_cfg.tx_power_fine   = wdata[TX_FINE_LSB +: 3];
    end
    if (write_hit && sel_bat) begin
      next_cfg.battery_threshold = wdata[BATT_THR_LSB +: 4];
    end
    if (write_hit && sel_flt) begin
      next_cfg.tx_filter_control      = wdata[TX_FILTER_BIT];
      next_cfg.fast_clock_wake        = wdata[FAST_WAKE_BIT];
      next_cfg.battery_monitor_enable = wdata[BATT_EN_BIT];
    end
  end

  // All configuration clears to zero on reset.
  // Software must reprogram the recommended values after every reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg <= CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Clear channel assessment: strength and threshold share one 8-bit code scale,
  // so a plain unsigned compare is the whole decision.
  logic next_busy;

  // Equal codes leave the channel free; only a strictly higher level is busy.
  assign next_busy = (rssi_level > cfg.cca_threshold);

  // Channel frequency: base plus five times the code.
  logic [11:0] next_freq;

  // Five times fifteen is 75, so twelve bits hold the sum without overflow.
  assign next_freq = BASE_FREQ_MHZ + 12'(FREQ_STEP_MHZ * 12'(cfg.channel));

  // Total attenuation in tenths of a dB; the fine step adds to the coarse one.
  logic [8:0] coarse_tenths;
  logic [8:0] next_atten;

  assign coarse_tenths = 9'(COARSE_STEP_TENTHS * 9'(cfg.tx_power_coarse));
  // The largest total is 363 tenths, which still fits in nine bits.
  assign next_atten    = coarse_tenths + FINE_TENTHS[cfg.tx_power_fine];

  // Derived radio values trail the configuration by one cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      channel_busy     <= 1'b0;
      channel_freq_mhz <= BASE_FREQ_MHZ;
      tx_atten_tenths  <= 9'h000;
    end else begin
      channel_busy     <= next_busy;
      channel_freq_mhz <= next_freq;
      tx_atten_tenths  <= next_atten;
    end
  end

  // Radio operations are granted only with the synthesizer running; a request made
  // while it is off is turned away and remembered for software.
  logic rx_go;
  logic tx_go;
  logic clear_rx_refused;
  logic clear_tx_refused;
  logic next_rx_refused;
  logic next_tx_refused;

  assign rx_go            = rx_request && cfg.synth_enable;
  assign tx_go            = tx_request && cfg.synth_enable;
  // Writing one to a refusal bit clears it; writing zero leaves it untouched.
  assign clear_rx_refused = write_hit && sel_evt && wdata[RX_REFUSED_BIT];
  assign clear_tx_refused = write_hit && sel_evt && wdata[TX_REFUSED_BIT];
  // A new refusal in the clearing cycle wins, so no event is lost.
  assign next_rx_refused  = (rx_request && !cfg.synth_enable) || (rx_refused && !clear_rx_refused);
  assign next_tx_refused  = (tx_request && !cfg.synth_enable) || (tx_refused && !clear_tx_refused);

  // Starts are registered so that every radio-side output comes from a flip-flop.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_start   <= 1'b0;
      tx_start   <= 1'b0;
      rx_refused <= 1'b0;
      tx_refused <= 1'b0;
    end else begin
      rx_start   <= rx_go;
      tx_start   <= tx_go;
      rx_refused <= next_rx_refused;
      tx_refused <= next_tx_refused;
    end
  end

  // Wake from sleep: the delay is chosen when the wake starts, so a write to the
  // recovery bit during a wake only affects the next one.
  typedef enum logic [0:0] {WAKE_IDLE, WAKE_COUNT} rcrb_wake_e;

  rcrb_wake_e             wake_state;
  rcrb_wake_e             next_wake_state;
  // Seventeen bits cover the slow limit of 119999 cycles at 40 MHz.
  logic [WAKE_CNT_W-1:0]  wake_cnt;
  logic [WAKE_CNT_W-1:0]  next_wake_cnt;
  logic [WAKE_CNT_W-1:0]  wake_limit;
  logic [WAKE_CNT_W-1:0]  next_wake_limit;
  logic                   next_clock_ready;
  logic                   wake_done;

  // The limit is latched at the start, so the count always meets a stable value.
  assign wake_done = (wake_cnt == wake_limit);

  always_comb begin
    next_wake_state  = wake_state;
    next_wake_cnt    = wake_cnt;
    next_wake_limit  = wake_limit;
    next_clock_ready = clock_ready;
    case (wake_state)
      WAKE_IDLE: begin
        if (wake_request) begin
          next_wake_state  = WAKE_COUNT;
          next_wake_cnt    = '0;
          next_clock_ready = 1'b0;
          next_wake_limit  = cfg.fast_clock_wake ? WAKE_CNT_W'(WAKE_FAST_LIMIT) :
                                                   WAKE_CNT_W'(WAKE_SLOW_LIMIT);
        end
      end
      WAKE_COUNT: begin
        // A wake request during the count is ignored; software waits for ready first.
        if (wake_done) begin
          next_wake_state  = WAKE_IDLE;
          next_clock_ready = 1'b1;
        end else begin
          next_wake_cnt = wake_cnt + WAKE_CNT_W'(1);
        end
      end
      default: begin
        // An illegal state falls back to idle with the clock marked running.
        next_wake_state  = WAKE_IDLE;
        next_clock_ready = 1'b1;
      end
    endcase
  end

  // The clock counts as running after reset; only a wake request stops it.
  // The wake limit resets to zero, but it is always loaded before it is used.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_state  <= WAKE_IDLE;
      wake_cnt    <= '0;
      wake_limit  <= '0;
      clock_ready <= 1'b1;
    end else begin
      wake_state  <= next_wake_state;
      wake_cnt    <= next_wake_cnt;
      wake_limit  <= next_wake_limit;
      clock_ready <= next_clock_ready;
    end
  end

  // Battery monitor, gated by its enable and fed the stored threshold code.
  // Undefined codes never raise the flag; the valid output marks them at the port, not in any register.
  rcrb_battery_monitor u_battery (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .enable          (cfg.battery_monitor_enable),
    .threshold       (cfg.battery_threshold),
    .supply_mv       (supply_mv),
    .low_flag        (battery_low_flag),
    .threshold_valid (battery_threshold_valid)
  );

endmodule // rcrb_register_bank

`default_nettype wire

// >>> testbench/rcrb_monitor.sv
// Port checker for the radio configuration register bank.
// Assumes it is bound into rcrb_register_bank with the same wake limits.
`default_nettype none

module rcrb_monitor
  import rcrb_pkg::*;
#(
  parameter int unsigned WAKE_FAST_LIMIT = 10,
  parameter int unsigned WAKE_SLOW_LIMIT = 30
)(
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic [7:0]          rssi_level,
  input wire logic                rx_request,
  input wire logic                tx_request,
  input wire logic                wake_request,
  input wire rcrb_pkg::rcrb_cfg_s cfg,
  input wire logic                channel_busy,
  input wire logic [11:0]         channel_freq_mhz,
  input wire logic                rx_start,
  input wire logic                tx_start,
  input wire logic                clock_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  int unsigned low_cnt;
  logic        fast_sel;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Length of a wake count, and the speed picked when it began.
  always_ff @(posedge ref_clk) begin
    low_cnt <= (rst || clock_ready) ? 0 : low_cnt + 1;
    if (wake_request && clock_ready) fast_sel <= cfg.fast_clock_wake;
  end

  // Past values are only trusted once the previous edge was out of reset.
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus answer not one cycle after request");
  a_answer_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  a_idle_data_zero: assert property (avs_waitrequest |-> avs_readdata == '0)
    else $error("read data not zero while waiting");
  a_busy_compare: assert property ($past(!rst) |-> channel_busy ==
    ($past(rssi_level) > $past(cfg.cca_threshold))) else $error("busy flag wrong");
  a_freq_map: assert property ($past(!rst) |-> channel_freq_mhz ==
    12'h965 + 12'h005 * $past(cfg.channel)) else $error("channel frequency wrong");
  a_rx_gate: assert property ($past(!rst) |-> rx_start ==
    $past(rx_request && cfg.synth_enable)) else $error("receive start wrong");
  a_tx_gate: assert property ($past(!rst) |-> tx_start ==
    $past(tx_request && cfg.synth_enable)) else $error("transmit start wrong");
  a_wake_drop: assert property (wake_request && clock_ready |=> !clock_ready)
    else $error("clock did not stop on wake");
  a_wake_time: assert property ($rose(clock_ready) |-> low_cnt ==
    (fast_sel ? WAKE_FAST_LIMIT : WAKE_SLOW_LIMIT) + 1) else $error("wake time wrong");

  // Main scenarios reached.
  c_write_done: cover property (!avs_waitrequest && avs_write);
  c_rx_start: cover property (rx_start);
  c_wake_done: cover property ($rose(clock_ready));

endmodule // rcrb_monitor

bind rcrb_register_bank rcrb_monitor #(
  .WAKE_FAST_LIMIT(WAKE_FAST_LIMIT), .WAKE_SLOW_LIMIT(WAKE_SLOW_LIMIT)
) u_mon (
  .ref_clk(ref_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rssi_level(rssi_level), .rx_request(rx_request), .tx_request(tx_request),
  .wake_request(wake_request), .cfg(cfg), .channel_busy(channel_busy),
  .channel_freq_mhz(channel_freq_mhz), .rx_start(rx_start), .tx_start(tx_start),
  .clock_ready(clock_ready)
);

`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the radio configuration register bank.
// Assumes the monitor is bound in; drives every input from one 40 MHz clock.
`default_nettype none

module tb;
  import rcrb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned FAST = 10;
  localparam int unsigned SLOW = 30;
  localparam logic [11:0] ADDR [7] = '{12'h0FC, 12'h800, 12'h804, 12'h808,
                                        12'h80C, 12'h814, 12'h818};
  localparam logic [7:0]  MASK [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'hF8, 8'hF0, 8'h98};
  localparam logic [8:0]  FINE [8] = '{9'h000, 9'h005, 9'h00C, 9'h013,
                                        9'h01C, 9'h025, 9'h031, 9'h03F};
  localparam logic [11:0] MV   [8] = '{12'h9C4, 12'hA28, 12'hA8C, 12'hAF0,
                                        12'hC1C, 12'hC80, 12'hCE4, 12'hDAC};

  logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic        rx_request, tx_request, wake_request, rx_start, tx_start;
  logic        channel_busy, clock_ready, battery_low_flag, bat_valid;
  logic [11:0] avs_address, supply_mv, channel_freq_mhz;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [7:0]  rssi_level;
  logic [8:0]  tx_atten_tenths;
  rcrb_cfg_s   cfg;
  int          errors, num_checks, cyc;

  rcrb_register_bank #(.WAKE_FAST_LIMIT(FAST), .WAKE_SLOW_LIMIT(SLOW)) dut (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rssi_level(rssi_level),
    .rx_request(rx_request), .tx_request(tx_request), .wake_request(wake_request),
    .supply_mv(supply_mv), .cfg(cfg), .channel_busy(channel_busy),
    .channel_freq_mhz(channel_freq_mhz), .tx_atten_tenths(tx_atten_tenths),
    .rx_start(rx_start), .tx_start(tx_start), .clock_ready(clock_ready),
    .battery_low_flag(battery_low_flag), .battery_threshold_valid(bat_valid)
  );

  // Free-running 40 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One bus cycle; waitrequest and read data are taken at the rising edge that completes it.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00, 4'hF);
    check(rd, {24'h0, exp});
  endtask

  task automatic pulse(input logic tx);
    @(posedge ref_clk);
    if (tx) tx_request <= 1'b1;
    else rx_request <= 1'b1;
    @(posedge ref_clk);
    rx_request <= 1'b0;
    tx_request <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 7; i++) rd_chk(ADDR[i], 8'h00);
    rd_chk(12'h0C0, 8'h00);
    check(32'(cfg == '0), 32'h1);
    check(32'(channel_freq_mhz), 32'h965);
    check(32'(clock_ready), 32'h1);
  endtask

  // Implemented bits hold, a write without byte lane 0 is ignored, a hole reads zero.
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      wr(ADDR[i], MASK[i]);
      rd_chk(ADDR[i], MASK[i]);
      xfer(1'b1, ADDR[i], 8'h00, 4'h0);
      rd_chk(ADDR[i], MASK[i]);
      wr(ADDR[i], 8'h00);
    end
    wr(12'h100, 8'hFF);
    rd_chk(12'h100, 8'h00);
    wr(12'h0FC, 8'h60);
    wr(12'h800, 8'h03);
    wr(12'h804, 8'h02);
    wr(12'h818, 8'h80);
    check(32'({cfg.cca_threshold, cfg.rf_optimise_field, cfg.vco_optimise_field,
               cfg.tx_filter_control}), 32'h0C0605);
  endtask

  task automatic t_cca();
    @(posedge ref_clk) rssi_level <= 8'h60;
    settle(3);
    check(32'(channel_busy), 32'h0);
    @(posedge ref_clk) rssi_level <= 8'h61;
    settle(3);
    check(32'(channel_busy), 32'h1);
  endtask

  task automatic t_tune();
    for (int c = 0; c < 16; c++) begin
      wr(12'h800, {4'(c), 4'h0});
      settle(2);
      check(32'(channel_freq_mhz), 32'(12'h965 + 12'h005 * c));
    end
    for (int c = 0; c < 4; c++) for (int f = 0; f < 8; f++) begin
      wr(12'h80C, {2'(c), 3'(f), 3'h0});
      settle(2);
      check(32'(tx_atten_tenths), 32'(9'h064 * c + FINE[f]));
    end
  endtask

  task automatic t_synth();
    wr(12'h808, 8'h00);
    pulse(1'b0);
    check(32'(rx_start), 32'h0);
    pulse(1'b1);
    check(32'(tx_start), 32'h0);
    rd_chk(12'h0C4, 8'h03);
    wr(12'h0C4, 8'h03);
    rd_chk(12'h0C4, 8'h00);
    wr(12'h808, 8'h80);
    check(32'(cfg.synth_enable), 32'h1);
    pulse(1'b0);
    check(32'(rx_start), 32'h1);
    pulse(1'b1);
    check(32'(tx_start), 32'h1);
  endtask

  task automatic t_batt();
    wr(12'h818, 8'h00);
    wr(12'h814, 8'hE0);
    @(posedge ref_clk) supply_mv <= 12'h000;
    settle(3);
    check(32'(battery_low_flag), 32'h0);
    wr(12'h818, 8'h08);
    for (int k = 0; k < 8; k++) begin
      wr(12'h814, {4'(k + 7), 4'h0});
      @(posedge ref_clk) supply_mv <= MV[k] - 12'h001;
      settle(3);
      check(32'({battery_low_flag, bat_valid}), 32'h3);
      rd_chk(12'h0C0, 8'h20);
      @(posedge ref_clk) supply_mv <= MV[k];
      settle(3);
      check(32'(battery_low_flag), 32'h0);
    end
    wr(12'h814, 8'h60);
    @(posedge ref_clk) supply_mv <= 12'h000;
    settle(3);
    check(32'({battery_low_flag, bat_valid}), 32'h0);
  endtask

  task automatic t_wake();
    int n;
    for (int s = 0; s < 2; s++) begin
      wr(12'h818, s ? 8'h10 : 8'h00);
      @(posedge ref_clk) wake_request <= 1'b1;
      @(posedge ref_clk) wake_request <= 1'b0;
      n = 0;
      settle(1);
      while (clock_ready === 1'b0 && n < 200) begin
        n++;
        settle(1);
      end
      check(32'(n), 32'((s ? FAST : SLOW) + 1));
    end
  endtask

  // Cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    {rst, avs_read, avs_write, rx_request, tx_request, wake_request} = 6'h20;
    {avs_address, supply_mv, rssi_level} = '0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_cca();
    t_tune();
    t_synth();
    t_batt();
    t_wake();
    finish_test();
  end

endmodule // tb

`default_nettype wire
